// ===== hdl/scc_device.sv
// Purpose: converter end: hold capture, conversion sequencing, readout
// Assumes: analog values arrive ready digitised on SAMPLE_I
// Notes:   result fifo sits between the converter and the readout port
module scc_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // write side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // read side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic [AW:0]  next_wr_ptr;
  logic [AW:0]  next_rd_ptr;
  logic         push;
  logic         pop;

  // extra pointer bit tells full from empty
  assign in_ready_o  = (wr_ptr - rd_ptr) != (AW+1)'(D);
  assign out_valid_o = wr_ptr != rd_ptr;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
endmodule

module scc_device
  import scc_pkg::*;
(
  // clock and reset
  input  wire logic                          CLK_I,
  input  wire logic                          RESET_I,
  // link to the host
  scc_link_if.dev                            LINK,
  // digitised inputs, channel k at bits 12k+11:12k
  input  wire logic [NUM_CHAN*DATA_W-1:0]    SAMPLE_I,
  // status
  output logic [NUM_PAIRS-1:0]               HELD_O,
  output logic                               CONVERTING_O
);
  import scc_pkg::*;

  logic                           rst;
  logic [NUM_PAIRS-1:0]           hold_q;
  logic [NUM_PAIRS-1:0]           accept;
  logic [NUM_PAIRS-1:0]           pending;
  logic [NUM_PAIRS-1:0]           next_pending;
  logic [2*DATA_W-1:0]            held [NUM_PAIRS];
  scc_conv_t                      state;
  scc_conv_t                      next_state;
  logic [3:0]                     cnt;
  logic [3:0]                     next_cnt;
  logic [1:0]                     cur;
  logic [1:0]                     next_cur;
  logic                           word_idx;
  logic                           next_word_idx;
  logic                           busy_n;
  logic                           push;
  logic                           fifo_in_ready;
  logic [WORD_W-1:0]              new_word;
  logic [2:0]                     new_code;
  logic [WORD_W-1:0]              res [NUM_CHAN];
  logic                           fifo_out_valid;
  logic [WORD_W-1:0]              fifo_out_data;
  logic                           rd_act;
  logic                           rd_q;
  logic                           rd_start;
  logic                           pop;
  logic [2:0]                     cyc_ptr;
  logic [2:0]                     next_cyc_ptr;
  logic [WORD_W-1:0]              out_word;
  logic [WORD_W-1:0]              next_out_word;
  logic                           out_oe;

  // pin reset and block reset act alike
  assign rst = RESET_I | ~LINK.reset_n;

  // a pair already waiting or converting ignores more strobes
  assign accept = hold_q & ~LINK.hold_n & ~pending;

  // channel code is pair times two plus input within pair
  assign new_code = {cur, word_idx};
  assign new_word = {1'b1, new_code,
                     held[cur][word_idx*DATA_W +: DATA_W]};
  assign push     = (state == SCC_LATCH) & fifo_in_ready;

  // conversion sequencer next state
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_cur      = cur;
    next_word_idx = word_idx;
    next_pending  = pending | accept;
    case (state)
      SCC_IDLE, SCC_ACQ: begin
        if (state == SCC_ACQ && cnt != 4'(ACQ_LEFT - 1)) begin
          next_cnt = cnt + 4'h1;
        end else if (pending != '0) begin
          // fixed priority decides holds that landed together
          next_state = SCC_CONV;
          next_cnt   = 4'h0;
          next_cur   = pending[0] ? 2'h0 : (pending[1] ? 2'h1 : 2'h2);
        end else begin
          next_state = SCC_IDLE;
        end
      end
      SCC_CONV: begin
        next_cnt = cnt + 4'h1;
        if (cnt == 4'(BUSY_CYCLES - 1)) begin
          next_state    = SCC_LATCH;
          next_word_idx = 1'b0;
        end
      end
      SCC_LATCH: begin
        // a full fifo stalls here, stretching busy
        if (fifo_in_ready) begin
          next_word_idx = 1'b1;
          if (word_idx) begin
            next_state         = SCC_ACQ;
            next_cnt           = 4'h0;
            next_pending[cur]  = accept[cur];
          end
        end
      end
      default: begin
        next_state = SCC_IDLE;
      end
    endcase
  end

  // conversion sequencer registers
  always_ff @(posedge CLK_I) begin
    if (rst) begin
      state    <= SCC_IDLE;
      cnt      <= 4'h0;
      cur      <= 2'h0;
      word_idx <= 1'b0;
      pending  <= '0;
      hold_q   <= '1;
      busy_n   <= 1'b1;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      cur      <= next_cur;
      word_idx <= next_word_idx;
      pending  <= next_pending;
      hold_q   <= LINK.hold_n;
      busy_n   <= ~(next_state == SCC_CONV || next_state == SCC_LATCH);
    end
  end

  // both inputs of a pair are frozen on the same edge
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_hold
    always_ff @(posedge CLK_I) begin
      if (accept[p]) begin
        held[p] <= SAMPLE_I[p*2*DATA_W +: 2*DATA_W];
      end
    end
  end

  // result registers, cleared by reset so their valid bit reads zero
  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_res
    always_ff @(posedge CLK_I) begin
      if (rst) begin
        res[c] <= '0;
      end else if (push && new_code == 3'(c)) begin
        res[c] <= new_word;
      end
    end
  end

  scc_fifo #(
    .W (WORD_W),
    .D (FIFO_DEPTH)
  ) scc_fifo_inst (
    .clk_i       (CLK_I),
    .rst_i       (rst),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (new_word),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_out_data)
  );

  // a read starts when read and select are first low together
  assign rd_act   = ~LINK.rd_n & ~LINK.cs_n;
  assign rd_start = rd_act & ~rd_q;
  assign pop      = rd_start & (LINK.mode_sel == MODE_FIFO) & fifo_out_valid;

  // readout next values, mode taken at the start of each read
  always_comb begin
    next_out_word = out_word;
    next_cyc_ptr  = cyc_ptr;
    if (rd_start) begin
      if (LINK.mode_sel <= MODE_LAST_DIRECT) begin
        next_out_word = res[LINK.mode_sel];
      end else if (LINK.mode_sel == MODE_CYCLE) begin
        next_out_word = res[cyc_ptr];
        next_cyc_ptr  = (cyc_ptr == 3'h5) ? 3'h0 : cyc_ptr + 3'h1;
      end else begin
        // empty fifo answers with the valid bit clear
        next_out_word = fifo_out_valid ? fifo_out_data : '0;
      end
    end
  end

  // readout registers
  always_ff @(posedge CLK_I) begin
    if (rst) begin
      out_word <= '0;
      out_oe   <= 1'b0;
      rd_q     <= 1'b0;
      cyc_ptr  <= MODE_RESET;
    end else begin
      out_word <= next_out_word;
      out_oe   <= rd_act;
      rd_q     <= rd_act;
      cyc_ptr  <= next_cyc_ptr;
    end
  end

  assign LINK.busy_n   = busy_n;
  assign LINK.data_out = out_word;
  assign LINK.data_oe  = out_oe;
  assign HELD_O        = pending;
  assign CONVERTING_O  = ~busy_n;
endmodule

// ===== hdl/scc_host.sv
// Purpose: host end: paces hold strobes, reset pulse and parallel reads
// Assumes: shares the device clock, so that clock always runs
// Notes:   requests arriving while a unit is busy are dropped
module scc_host
  import scc_pkg::*;
(
  // clock and reset
  input  wire logic                 CLK_I,
  input  wire logic                 RESET_I,
  // conversion requests, one bit per pair
  input  wire logic [NUM_PAIRS-1:0] START_I,
  output logic [NUM_PAIRS-1:0]      START_READY_O,
  input  wire logic                 RESET_REQ_I,
  // read requests
  input  wire logic                 READ_I,
  input  wire logic [2:0]           MODE_I,
  output logic                      READ_READY_O,
  output logic [WORD_W-1:0]         WORD_O,
  output logic                      WORD_VALID_O,
  output logic                      CONV_BUSY_O,
  // link to the device
  scc_link_if.host                  LINK
);
  import scc_pkg::*;

  logic [3:0]       rst_cnt;
  logic [3:0]       next_rst_cnt;
  logic [3:0]       gap_cnt;
  logic [3:0]       next_gap_cnt;
  logic             rst_busy;
  scc_rd_t          rd_state;
  scc_rd_t          next_rd_state;
  logic [3:0]       rd_cnt;
  logic [3:0]       next_rd_cnt;
  logic [2:0]       mode;
  logic [2:0]       next_mode;
  logic [WORD_W-1:0] word;
  logic [WORD_W-1:0] next_word;
  logic             word_valid;
  logic             next_word_valid;

  // no hold may fall while reset is low or just released
  assign rst_busy = (rst_cnt != 4'h0) | (gap_cnt != 4'h0);

  // reset pulse and recovery gap
  always_comb begin
    next_rst_cnt = rst_cnt;
    next_gap_cnt = gap_cnt;
    if (RESET_REQ_I && !rst_busy) begin
      next_rst_cnt = 4'(RST_LOW_CYC);
    end else if (rst_cnt != 4'h0) begin
      next_rst_cnt = rst_cnt - 4'h1;
      if (rst_cnt == 4'h1) begin
        next_gap_cnt = 4'(RST_GAP_CYC);
      end
    end else if (gap_cnt != 4'h0) begin
      next_gap_cnt = gap_cnt - 4'h1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rst_cnt <= 4'h0;
      gap_cnt <= 4'h0;
    end else begin
      rst_cnt <= next_rst_cnt;
      gap_cnt <= next_gap_cnt;
    end
  end

  assign LINK.reset_n = (rst_cnt == 4'h0);

  // one strobe pacer per pair: low phase, then high recovery
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_hold
    logic       low;
    logic       next_low;
    logic [3:0] cnt;
    logic [3:0] next_cnt;

    assign START_READY_O[p] = ~low & (cnt == 4'h0) & ~rst_busy;

    always_comb begin
      next_low = low;
      next_cnt = cnt;
      if (START_I[p] && START_READY_O[p]) begin
        next_low = 1'b1;
        next_cnt = 4'(HOLD_LOW_CYC);
      end else if (cnt != 4'h0) begin
        next_cnt = cnt - 4'h1;
        if (low && cnt == 4'h1) begin
          next_low = 1'b0;
          next_cnt = 4'(HOLD_HIGH_CYC);
        end
      end
    end

    always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
        low <= 1'b0;
        cnt <= 4'h0;
      end else begin
        low <= next_low;
        cnt <= next_cnt;
      end
    end

    assign LINK.hold_n[p] = ~low;
  end

  // read sequencer: address setup, strobe, then high recovery
  always_comb begin
    next_rd_state   = rd_state;
    next_rd_cnt     = rd_cnt;
    next_mode       = mode;
    next_word       = word;
    next_word_valid = 1'b0;
    case (rd_state)
      SCC_RD_IDLE: begin
        if (READ_I) begin
          next_rd_state = SCC_RD_SETUP;
          next_mode     = MODE_I;
          next_rd_cnt   = 4'(SETUP_CYC - 1);
        end
      end
      SCC_RD_SETUP: begin
        if (rd_cnt == 4'h0) begin
          next_rd_state = SCC_RD_STROBE;
          next_rd_cnt   = 4'(RD_LOW_CYC - 1);
        end else begin
          next_rd_cnt = rd_cnt - 4'h1;
        end
      end
      SCC_RD_STROBE: begin
        if (rd_cnt == 4'h0) begin
          next_rd_state   = SCC_RD_RECOV;
          next_word       = LINK.data;
          next_word_valid = 1'b1;
          next_rd_cnt     = 4'(RD_HIGH_CYC - 1);
        end else begin
          next_rd_cnt = rd_cnt - 4'h1;
        end
      end
      SCC_RD_RECOV: begin
        if (rd_cnt == 4'h0) begin
          next_rd_state = SCC_RD_IDLE;
        end else begin
          next_rd_cnt = rd_cnt - 4'h1;
        end
      end
      default: begin
        next_rd_state = SCC_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rd_state   <= SCC_RD_IDLE;
      rd_cnt     <= 4'h0;
      mode       <= MODE_RESET;
      word       <= '0;
      word_valid <= 1'b0;
    end else begin
      rd_state   <= next_rd_state;
      rd_cnt     <= next_rd_cnt;
      mode       <= next_mode;
      word       <= next_word;
      word_valid <= next_word_valid;
    end
  end

  // mode lines stay steady across the whole strobe
  assign LINK.mode_sel = mode;
  assign LINK.rd_n     = (rd_state != SCC_RD_STROBE);
  assign LINK.cs_n     = (rd_state != SCC_RD_STROBE);
  assign READ_READY_O  = (rd_state == SCC_RD_IDLE);
  assign WORD_O        = word;
  assign WORD_VALID_O  = word_valid;
  assign CONV_BUSY_O   = ~LINK.busy_n;
endmodule

// ===== hdl/scc_link_if.sv
// Purpose: pins between the converter control and its host
// Assumes: both ends on the same clock
// Notes:   the data bus is modelled as drive plus enable, no float
interface scc_link_if;
  logic [2:0]  hold_n;    // per pair hold strobe, low holds
  logic        reset_n;
  logic        rd_n;
  logic        cs_n;
  logic [2:0]  mode_sel;
  logic        busy_n;
  logic [15:0] data_out;
  logic        data_oe;
  logic [15:0] data;      // resolved bus level seen by the host

  // an undriven bus reads as zero here
  assign data = data_oe ? data_out : 16'h0000;

  modport dev  (input hold_n, reset_n, rd_n, cs_n, mode_sel,
                output busy_n, data_out, data_oe);
  modport host (output hold_n, reset_n, rd_n, cs_n, mode_sel,
                input busy_n, data);
endinterface

// ===== hdl/scc_pkg.sv
// Purpose: shared constants for the six channel sample/convert control pair
// Assumes: one 10 MHz clock shared by both ends, synchronous inputs
// Notes:   times are kept in ns and turned into cycles here
//
// What this block does
// - host holds pair strobe low long enough
// - strobe fall holds both pair inputs together
// - busy low 15 cycles, high after latch
// - read plus select low drives result out
// - conversion and acquisition phases share period
// - host may read during next conversion
// - conversion clock sets the sample rate
// - all three strobes together hold six
// - six result words: valid, channel, 12 bits
// - mode lines pick direct, cycle or fifo
// - fifo lets one pair fill all slots
// - host keeps clock running, not too fast
// - reset clears results, aborts, resamples
// - host reset low and gap before hold
// - result readable once busy returns high
// - one conversion takes at least 16 cycles
// - same cycle holds convert A, B, C order
// - repeat strobes ignored until conversion done
// - top bit set only for valid word
// - channel codes A0..C1 are 000..101
package scc_pkg;
  localparam int CLK_PERIOD_NS  = 100;
  localparam int REF_PERIOD_NS  = 125;  // 8 MHz reference rate
  localparam int CONV_NS        = 1750;
  localparam int ACQ_NS         = 250;
  localparam int CONV_CYCLES    = (CONV_NS + ACQ_NS) / REF_PERIOD_NS;
  localparam int BUSY_CYCLES    = 13;
  localparam int WORDS_PER_PAIR = 2;
  localparam int ACQ_LEFT       = CONV_CYCLES - BUSY_CYCLES - WORDS_PER_PAIR;
  // host side minimum times, rounded up to whole cycles
  localparam int HOLD_LOW_NS    = 20;
  localparam int HOLD_HIGH_NS   = 15;
  localparam int RST_LOW_NS     = 20;
  localparam int RST_GAP_NS     = 20;
  localparam int ADDR_SETUP_NS  = 10;
  localparam int RD_LOW_NS      = 50;
  localparam int RD_HIGH_NS     = 30;
  localparam int HOLD_LOW_CYC   =
    (HOLD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_HIGH_CYC  =
    (HOLD_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_LOW_CYC    =
    (RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_GAP_CYC    =
    (RST_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC      =
    (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // one extra strobe cycle covers the device's registered data output
  localparam int RD_LOW_CYC     =
    (RD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int RD_HIGH_CYC    =
    (RD_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // word layout
  localparam int WORD_W     = 16;
  localparam int DATA_W     = 12;
  localparam int VALID_BIT  = 15;
  localparam int CODE_LSB   = 12;
  localparam int NUM_PAIRS  = 3;
  localparam int NUM_CHAN   = 6;
  localparam int FIFO_DEPTH = 16;
  // mode select codes
  localparam logic [2:0] MODE_LAST_DIRECT = 3'h5;
  localparam logic [2:0] MODE_CYCLE       = 3'h6;
  localparam logic [2:0] MODE_FIFO        = 3'h7;
  localparam logic [2:0] MODE_RESET       = 3'h0;

  typedef enum logic [1:0] {
    SCC_IDLE  = 2'b00,
    SCC_CONV  = 2'b01,
    SCC_LATCH = 2'b11,
    SCC_ACQ   = 2'b10
  } scc_conv_t;

  typedef enum logic [1:0] {
    SCC_RD_IDLE   = 2'b00,
    SCC_RD_SETUP  = 2'b01,
    SCC_RD_STROBE = 2'b11,
    SCC_RD_RECOV  = 2'b10
  } scc_rd_t;
endpackage

// ===== tb/scc_link_sva.sv
// Purpose: concurrent checks on the link between host and converter ends
// Assumes: one clock, synchronous active high reset, device reset on reset_n
// Notes:   busy counts are kept in small helper counters, not repetitions
module scc_link_sva (
  // clock and reset
  input wire logic        CLK_I,
  input wire logic        RESET_I,
  // host driven pins
  input wire logic [2:0]  hold_n,
  input wire logic        reset_n,
  input wire logic        rd_n,
  input wire logic        cs_n,
  // device driven pins
  input wire logic        busy_n,
  input wire logic [15:0] data_out,
  input wire logic        data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       busy_q;
  logic       next_busy_q;
  logic [7:0] low_cnt;
  logic [7:0] next_low_cnt;
  logic [7:0] per_cnt;
  logic [7:0] next_per_cnt;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I || !reset_n);

  // low run length and spacing of busy falls, both saturate to stay sane
  always_comb begin
    next_busy_q  = busy_n;
    next_low_cnt = busy_n ? 8'h00 : low_cnt + {7'h0, low_cnt != 8'hff};
    next_per_cnt = (busy_q && !busy_n) ? 8'h01
                                        : per_cnt + {7'h0, per_cnt != 8'hff};
  end

  // a device reset aborts conversions, so counters restart there too
  always_ff @(posedge CLK_I) begin
    if (RESET_I || !reset_n) begin
      busy_q  <= 1'b1;
      low_cnt <= 8'h00;
      per_cnt <= 8'hff;
    end else begin
      busy_q  <= next_busy_q;
      low_cnt <= next_low_cnt;
      per_cnt <= next_per_cnt;
    end
  end

  a_busy_low_len: assert property ($rose(busy_n) |-> low_cnt == 8'h0f)
    else $error("busy low run not 15 cycles");
  a_conv_period: assert property ($fell(busy_n) |-> per_cnt >= 8'h10)
    else $error("conversions closer than 16 cycles");
  a_hold_starts: assert property (|($past(hold_n) & ~hold_n) |->
    ##[0:60] !busy_n)
    else $error("hold fall not followed by busy");
  a_oe_follows: assert property (data_oe == $past(!rd_n && !cs_n))
    else $error("output enable not one cycle after read");
  a_data_holds: assert property (data_oe && $past(data_oe) |->
    $stable(data_out))
    else $error("output word changed during read");
  a_chan_code: assert property (data_oe && data_out[15] |->
    data_out[14:12] <= 3'h5)
    else $error("channel code out of range");
  a_reset_clears: assert property (disable iff (RESET_I)
    !reset_n |=> busy_n && !data_oe)
    else $error("device reset left busy or output on");
  a_reset_gap: assert property ($rose(reset_n) |-> hold_n == 3'h7)
    else $error("hold fell right after device reset");
  a_rd_with_cs: assert property ((rd_n == cs_n) and
    ($fell(rd_n) |=> !rd_n ##1 rd_n))
    else $error("read strobe not two cycles with select");
endmodule

// ===== tb/six_channel_sample_convert_control_tb.sv
// Purpose: drives host requests and samples, judges words read back
// Assumes: host and device share the 10 MHz clock and the reset
// Notes:   samples carry channel and run number so words are traceable
module six_channel_sample_convert_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import scc_pkg::*;

  logic                       clk = 1'b0;
  logic                       rst = 1'b1;
  logic [NUM_PAIRS-1:0]       start;
  logic [NUM_PAIRS-1:0]       start_rdy;
  logic [NUM_PAIRS-1:0]       held;
  logic                       rst_req;
  logic                       rd_req;
  logic                       rd_rdy;
  logic                       wvalid;
  logic                       conv;
  logic                       cbusy;
  logic [2:0]                 mode;
  logic [WORD_W-1:0]          word;
  logic [NUM_CHAN*DATA_W-1:0] samp_bus;
  int                         mismatches = 0;
  int                         n_tests = 0;
  int                         cycles = 0;

  // 100 ns period
  always #50 clk = ~clk;

  scc_link_if link_inst ();
  scc_device scc_device_inst (.CLK_I(clk), .RESET_I(rst), .LINK(link_inst),
    .SAMPLE_I(samp_bus), .HELD_O(held), .CONVERTING_O(conv));
  scc_host scc_host_inst (.CLK_I(clk), .RESET_I(rst), .START_I(start),
    .START_READY_O(start_rdy), .RESET_REQ_I(rst_req), .READ_I(rd_req),
    .MODE_I(mode), .READ_READY_O(rd_rdy), .WORD_O(word),
    .WORD_VALID_O(wvalid), .CONV_BUSY_O(cbusy), .LINK(link_inst));
  scc_link_sva scc_link_sva_inst (.CLK_I(clk), .RESET_I(rst),
    .hold_n(link_inst.hold_n), .reset_n(link_inst.reset_n),
    .rd_n(link_inst.rd_n), .cs_n(link_inst.cs_n),
    .busy_n(link_inst.busy_n), .data_out(link_inst.data_out),
    .data_oe(link_inst.data_oe));

  // expected word: valid flag, channel code, traceable sample
  function automatic logic [15:0] wexp(int ch, int k);
    return {1'b1, 3'(ch), 12'(12'h800 + ch * 16 + k)};
  endfunction

  task automatic check(string name, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic complete_run;
    if (mismatches == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic set_samples(int k);
    @(posedge clk);
    for (int ch = 0; ch < NUM_CHAN; ch++)
      samp_bus[12*ch +: 12] <= 12'(12'h800 + ch * 16 + k);
  endtask

  // one accepted start pulse for the pairs in m
  task automatic start_pair(logic [2:0] m);
    @(negedge clk);
    for (int i = 0; i < 50 && (start_rdy & m) !== m; i++) @(negedge clk);
    @(posedge clk) start <= m;
    @(posedge clk) start <= 3'h0;
  endtask

  task automatic wait_done;
    repeat (6) @(negedge clk);
    for (int i = 0; i < 300 && {held, conv} !== 4'h0; i++) @(negedge clk);
    check("idle", 16'h0000, {12'h0, held, conv});
  endtask

  task automatic read_word(logic [2:0] m, output logic [15:0] w);
    @(negedge clk);
    for (int i = 0; i < 50 && rd_rdy !== 1'b1; i++) @(negedge clk);
    @(posedge clk);
    rd_req <= 1'b1;
    mode   <= m;
    @(posedge clk) rd_req <= 1'b0;
    for (int i = 0; i < 20 && wvalid !== 1'b1; i++) @(negedge clk);
    check("rd_done", 16'h0001, {15'h0, wvalid});
    w = word;
  endtask

  task automatic host_reset;
    @(posedge clk) rst_req <= 1'b1;
    @(posedge clk) rst_req <= 1'b0;
    @(negedge clk);
    check("rst_pulse", 16'h0000, {12'h0, link_inst.reset_n, start_rdy});
    repeat (4) @(posedge clk);
  endtask

  task automatic t_reset_state;
    @(negedge clk);
    check("rst_pins", 16'h01e8, {7'h0, start_rdy, rd_rdy,
      link_inst.data_oe, link_inst.busy_n, held});
  endtask

  task automatic t_single;
    int n;
    logic [15:0] w;
    set_samples(1);
    start_pair(3'h1);
    for (int i = 0; i < 10 && cbusy !== 1'b1; i++) @(negedge clk);
    n = 0;
    while (cbusy === 1'b1 && n < 40) begin
      n++;
      @(negedge clk);
    end
    check("busy_len", 16'd15, 16'(n));
    wait_done;
    read_word(3'h0, w);
    check("a0", wexp(0, 1), w);
    read_word(3'h1, w);
    check("a1", wexp(1, 1), w);
    read_word(3'h2, w);
    check("b0_empty", 16'h0000, w);
  endtask

  task automatic t_all_fifo;
    logic [15:0] w;
    host_reset;
    read_word(3'h0, w);
    check("cleared", 16'h0000, w);
    set_samples(2);
    start_pair(3'h7);
    for (int i = 0; i < 10 && held === 3'h0; i++) @(negedge clk);
    check("held_all", 16'h0007, {13'h0, held});
    wait_done;
    for (int ch = 0; ch < NUM_CHAN; ch++) begin
      read_word(3'(ch), w);
      check("direct", wexp(ch, 2), w);
    end
    for (int ch = 0; ch < NUM_CHAN; ch++) begin
      read_word(MODE_FIFO, w);
      check("fifo_order", wexp(ch, 2), w);
    end
    read_word(MODE_FIFO, w);
    check("fifo_end", 16'h0000, w);
    for (int ch = 0; ch < NUM_CHAN; ch++) begin
      read_word(MODE_CYCLE, w);
      check("cycle", wexp(ch, 2), w);
    end
  endtask

  // a repeat strobe mid conversion must not add words
  task automatic t_one_pair;
    logic [15:0] w;
    host_reset;
    for (int k = 0; k < 3; k++) begin
      set_samples(4 + k);
      start_pair(3'h1);
      if (k == 0) begin
        repeat (4) @(posedge clk);
        start_pair(3'h1);
      end
      wait_done;
    end
    for (int k = 0; k < 3; k++)
      for (int j = 0; j < 2; j++) begin
        read_word(MODE_FIFO, w);
        check("pair_fill", wexp(j, 4 + k), w);
      end
    read_word(MODE_FIFO, w);
    check("no_extra", 16'h0000, w);
  endtask

  // hang guard, the full run needs a few hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      complete_run;
    end
  end

  initial begin
    start    = 3'h0;
    rst_req  = 1'b0;
    rd_req   = 1'b0;
    mode     = 3'h0;
    samp_bus = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset_state;
    t_single;
    t_all_fifo;
    t_one_pair;
    complete_run;
  end
endmodule
